// ==== rtl/brk_pkg.sv ====
// constants for the break condition control block
package brk_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_ID_A = 8'h08;
  localparam logic [7:0] OFS_ID_B = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  // control register reset value and writable bits
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WMASK = 32'h0030_fcc9;
  // control field positions
  localparam int B_ID_MASK_A = 21;
  localparam int B_ID_MASK_B = 20;
  localparam int B_CPU_FLAG_A = 15;
  localparam int B_CPU_FLAG_B = 14;
  localparam int B_DMA_FLAG_A = 13;
  localparam int B_DMA_FLAG_B = 12;
  localparam int B_PC_TRACE = 11;
  localparam int B_AFTER_A = 10;
  localparam int B_DATA_B = 7;
  localparam int B_AFTER_B = 6;
  localparam int B_CHAIN = 3;
  localparam int B_COUNT_ON = 0;
  // execution count
  localparam int COUNT_W = 12;
  localparam logic [11:0] COUNT_ONE = 12'h001;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  // interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_BREAK = 0;
  localparam int IRQ_FLAG = 1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : brk_pkg

// ==== rtl/brk_axi_slave.sv ====
// axi4-lite slave front end: one write and one read at a time
module brk_axi_slave
  import brk_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_q; // write address held
  logic w_q; // write data held
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  ////////////////////////////////////////////////////////////////////////////
  // write channels taken in either order, response after both
  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_q && !S_AXI_BVALID;
  assign wr_en = aw_q && w_q && !S_AXI_BVALID;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      // commit and answer
      if (wr_en)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read: data one cycle after address taken
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_en = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_addr = S_AXI_ARADDR;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (rd_en)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_ok ? rd_data : 32'h0000_0000;
      S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
endmodule : brk_axi_slave

// ==== rtl/brk_control.sv ====
// break condition control: options, match flags, count and break decision
// Contract
// R1 - control register 32 bits, reset zero
// R2 - reserved bits read zero, writes ignored
// R3 - channel A identifier checked unless mask set
// R4 - channel B identifier checked unless mask set
// R5 - cpu match A flag sets, software clears
// R6 - cpu match B flag sets, software clears
// R7 - dma match A flag sets, software clears
// R8 - dma match B flag sets, software clears
// R9 - pc trace enable bit, reset off
// R10 - channel A fetch break before or after
// R11 - channel B data compare optional
// R12 - channel B fetch break before or after
// R13 - independent or sequential channel use
// R14 - count break enable on channel B
// R15 - count decrements, break on match at one
// R16 - channel A eight-bit identifier, not reset
// R17 - sequential: B after recorded A breaks
// R18 - writing one leaves match flags unchanged
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
module brk_control
  import brk_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // one-cycle qualified bus cycle strobes from the comparators
  input wire logic CYCLE_VALID,
  input wire logic CYCLE_IS_DMA,
  input wire logic CYCLE_IS_FETCH,
  input wire logic [7:0] CYCLE_ID,
  input wire logic ADDR_MATCH_A,
  input wire logic ADDR_MATCH_B,
  input wire logic DATA_MATCH_B,
  // instruction retire strobe for after-execution breaks
  input wire logic INSN_DONE,
  // option levels, break request and interrupt to the rest of the controller
  output logic PC_TRACE_ON,
  output logic DATA_COMPARE_ON_B,
  output logic BREAK_REQ,
  output logic IRQ
);
  // architectural state
  logic [31:0] control_q; // control register
  logic [11:0] count_q; // execution count
  logic [7:0] id_a_q; // channel A identifier compare
  logic [7:0] id_b_q; // channel B identifier compare
  logic [IRQ_W-1:0] irq_stat_q; // sticky events
  logic [IRQ_W-1:0] irq_en_q; // event enables
  logic seq_armed_q; // channel A seen in sequential mode
  logic pend_after_q; // break waiting for instruction end
  logic break_q; // break request pulse register
  // register side of the slave
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  // decode and condition terms
  logic [31:0] bmask; // byte enables as bit mask
  logic ctl_wr; // control written this cycle
  logic hit_a; // channel A condition met
  logic hit_b; // channel B condition met
  logic b_fires; // channel B qualifies for a break
  logic a_fires; // channel A qualifies for a break
  logic fire_now; // break before execution
  logic fire_later; // break after execution
  logic [IRQ_W-1:0] irq_event;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  // one write and one read at a time
  brk_axi_slave u_slave (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    // register side
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // byte enables widened to bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_bmask
      // one strobe per eight data bits
      assign bmask[gi*8 +: 8] = {8{wr_strb[gi]}};
    end
  endgenerate

  // decode of mapped write addresses
  always_comb
  begin
    unique case (wr_addr)
      OFS_CONTROL, OFS_COUNT, OFS_ID_A, OFS_ID_B,
      OFS_IRQ_STATUS, OFS_IRQ_ENABLE, OFS_IRQ_CLEAR: wr_ok = 1'b1;
      // unmapped: error response
      default: wr_ok = 1'b0;
    endcase
  end

  // control register write strobe
  assign ctl_wr = wr_en && (wr_addr == OFS_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // channel condition evaluation
  always_comb
  begin
    // identifier takes part only while its mask bit is clear
    hit_a = CYCLE_VALID && ADDR_MATCH_A &&
      (control_q[B_ID_MASK_A] || CYCLE_ID == id_a_q); // [R3] [R16]
    // channel B may need a data hit
    hit_b = CYCLE_VALID && ADDR_MATCH_B &&
      (control_q[B_ID_MASK_B] || CYCLE_ID == id_b_q) && // [R4]
      (!control_q[B_DATA_B] || DATA_MATCH_B); // [R11]
    // sequential mode needs A recorded before B
    a_fires = hit_a && !control_q[B_CHAIN]; // [R13]
    // count break holds B until one
    b_fires = hit_b && (!control_q[B_CHAIN] || seq_armed_q) && // [R17]
      (!control_q[B_COUNT_ON] || count_q == COUNT_ONE); // [R14] [R15]
    // fetch breaks may wait until the instruction has executed
    fire_now = (a_fires && !(CYCLE_IS_FETCH && control_q[B_AFTER_A])) ||
      (b_fires && !(CYCLE_IS_FETCH && control_q[B_AFTER_B])); // [R10] [R12]
    // after mode waits for retire
    fire_later = (a_fires && CYCLE_IS_FETCH && control_q[B_AFTER_A]) ||
      (b_fires && CYCLE_IS_FETCH && control_q[B_AFTER_B]); // [R10] [R12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: options plus sticky match flags
  always_ff @(posedge CLK)
  begin
    // power-on: all options and flags off
    if (SYS_RST)
      control_q <= CONTROL_RESET; // [R1]
    else
    begin
      // options take the written value, reserved bits stay zero
      if (ctl_wr)
        control_q <= (control_q & ~(bmask & CONTROL_WMASK)) |
          (wr_data & bmask & CONTROL_WMASK); // [R2] [R9]
      // flags: write 0 clears, write 1 keeps, hardware set wins
      if (ctl_wr && wr_strb[1])
      begin
        control_q[B_CPU_FLAG_A] <= control_q[B_CPU_FLAG_A] &
          wr_data[B_CPU_FLAG_A]; // [R18]
        control_q[B_CPU_FLAG_B] <= control_q[B_CPU_FLAG_B] &
          wr_data[B_CPU_FLAG_B]; // [R18]
        control_q[B_DMA_FLAG_A] <= control_q[B_DMA_FLAG_A] &
          wr_data[B_DMA_FLAG_A]; // [R18]
        control_q[B_DMA_FLAG_B] <= control_q[B_DMA_FLAG_B] &
          wr_data[B_DMA_FLAG_B]; // [R18]
      end
      // hardware sets last: set beats clear
      // processor cycles
      if (hit_a && !CYCLE_IS_DMA)
        control_q[B_CPU_FLAG_A] <= 1'b1; // [R5]
      if (hit_b && !CYCLE_IS_DMA)
        control_q[B_CPU_FLAG_B] <= 1'b1; // [R6]
      // dma cycles
      if (hit_a && CYCLE_IS_DMA)
        control_q[B_DMA_FLAG_A] <= 1'b1; // [R7]
      if (hit_b && CYCLE_IS_DMA)
        control_q[B_DMA_FLAG_B] <= 1'b1; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution count: decrements per channel B match while enabled, stopping at one
  always_ff @(posedge CLK)
  begin
    // count cleared at power-on
    if (SYS_RST)
      count_q <= COUNT_RESET;
    else if (wr_en && wr_addr == OFS_COUNT && |wr_strb[1:0])
    begin
      // each lane replaces only its own bits
      if (wr_strb[0])
        count_q[7:0] <= wr_data[7:0];
      if (wr_strb[1])
        count_q[COUNT_W-1:8] <= wr_data[COUNT_W-1:8];
    end
    // B match counts down, never below one
    else if (hit_b && control_q[B_COUNT_ON] &&
             (!control_q[B_CHAIN] || seq_armed_q) && count_q > COUNT_ONE)
      count_q <= count_q - COUNT_ONE; // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // identifier compare values: not reset
  always_ff @(posedge CLK)
  begin
    // whole identifier on lane 0
    if (wr_en && wr_addr == OFS_ID_A && wr_strb[0])
      id_a_q <= wr_data[7:0]; // [R16]
    if (wr_en && wr_addr == OFS_ID_B && wr_strb[0])
      id_b_q <= wr_data[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence tracker: remembers channel A until the chain completes
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      seq_armed_q <= 1'b0;
    // leaving sequential mode forgets A
    else if (!control_q[B_CHAIN])
      seq_armed_q <= 1'b0;
    // a completed chain rearms
    else if (b_fires)
      seq_armed_q <= 1'b0; // [R17]
    // A only records, never breaks
    else if (hit_a)
      seq_armed_q <= 1'b1; // [R17]
  end

  ////////////////////////////////////////////////////////////////////////////
  // break request: immediate, or held until the instruction retires
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      pend_after_q <= 1'b0;
      break_q <= 1'b0;
    end
    else
    begin
      // now, or deferred until retire
      break_q <= fire_now || (pend_after_q && INSN_DONE);
      if (fire_later)
        pend_after_q <= 1'b1; // [R10] [R12]
      // retire clears a pending break
      else if (INSN_DONE)
        pend_after_q <= 1'b0;
    end
  end

  // registered one-cycle break pulse
  assign BREAK_REQ = break_q;
  // option levels from the register
  assign PC_TRACE_ON = control_q[B_PC_TRACE]; // [R9]
  assign DATA_COMPARE_ON_B = control_q[B_DATA_B];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky status, enable, write-one clear; set beats clear
  // events: break issued, any hit
  assign irq_event[IRQ_BREAK] = break_q;
  assign irq_event[IRQ_FLAG] = hit_a || hit_b;

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
    end
    else
    begin
      // enables on lane 0
      if (wr_en && wr_addr == OFS_IRQ_ENABLE && wr_strb[0])
        irq_en_q <= wr_data[IRQ_W-1:0];
      // write one clears, new events stay
      if (wr_en && wr_addr == OFS_IRQ_CLEAR && wr_strb[0])
        irq_stat_q <= (irq_stat_q & ~wr_data[IRQ_W-1:0]) | irq_event;
      else
        irq_stat_q <= irq_stat_q | irq_event;
    end
  end

  // level while an enabled bit is set
  assign IRQ = |(irq_stat_q & irq_en_q);

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reserved bits read zero
  always_comb
  begin
    // mapped offsets read zero by default
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      OFS_CONTROL: rd_data = control_q; // [R2]
      OFS_COUNT: rd_data[COUNT_W-1:0] = count_q;
      OFS_ID_A: rd_data[7:0] = id_a_q;
      OFS_ID_B: rd_data[7:0] = id_b_q;
      OFS_IRQ_STATUS: rd_data[IRQ_W-1:0] = irq_stat_q;
      OFS_IRQ_ENABLE: rd_data[IRQ_W-1:0] = irq_en_q;
      // clear register is write only
      OFS_IRQ_CLEAR: rd_data = 32'h0000_0000;
      // unmapped: error response
      default: rd_ok = 1'b0;
    endcase
  end
endmodule : brk_control

// ==== tb/brk_bus_model.sv ====
// bus cycle source standing in for the core and the dma engine
module brk_bus_model
(
  input wire logic clk,
  output logic cyc_valid,
  output logic cyc_dma,
  output logic cyc_fetch,
  output logic [7:0] cyc_id,
  output logic addr_a,
  output logic addr_b,
  output logic data_b,
  output logic insn_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet bus at time zero
  initial
    {cyc_valid, cyc_dma, cyc_fetch, cyc_id, addr_a, addr_b, data_b,
      insn_done} = '0;
  ////////////////////////////////
  // one qualified cycle, k holds dma, fetch, hit a, hit b, data hit;
  // qualifiers flip once valid drops so a stale level is never seen
  task automatic bus_cycle(input logic [4:0] k, input logic [7:0] id);
    logic [12:0] q;
    q = {k[4:3], id, k[2:0]};
    @(posedge clk);
    cyc_valid <= 1'b1;
    {cyc_dma, cyc_fetch, cyc_id, addr_a, addr_b, data_b} <= q;
    @(posedge clk);
    cyc_valid <= 1'b0;
    {cyc_dma, cyc_fetch, cyc_id, addr_a, addr_b, data_b} <= ~q;
  endtask : bus_cycle
  // retire strobe, one clock wide
  task automatic insn();
    @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
  endtask : insn
endmodule : brk_bus_model

// ==== tb/brk_control_asserts.sv ====
// port checks for the break condition control block
module brk_control_asserts
  import brk_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic CYCLE_VALID,
  input wire logic INSN_DONE,
  input wire logic PC_TRACE_ON,
  input wire logic BREAK_REQ,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////
  // address and data taken together, read address taken
  sequence s_wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  // outputs quiet once reset has been seen
  property p_rst_quiet;
    disable iff (1'b0) SYS_RST |=> !BREAK_REQ && !IRQ && !PC_TRACE_ON;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("output active after reset");
  // a break needs a bus cycle or a retire just before it
  property p_brk_cause;
    BREAK_REQ |-> $past(CYCLE_VALID) || $past(INSN_DONE);
  endproperty
  a_brk_cause: assert property (p_brk_cause)
    else $error("break without a cause");
  // trace option moves only with a write response
  property p_trace_w;
    $changed(PC_TRACE_ON) |-> S_AXI_BVALID || $past(S_AXI_BVALID);
  endproperty
  a_trace_w: assert property (p_trace_w)
    else $error("trace option moved without a write");
  property p_w_resp;
    s_wr_both |-> ##[1:2] S_AXI_BVALID;
  endproperty
  a_w_resp: assert property (p_w_resp)
    else $error("write response late");
  property p_r_resp;
    s_rd_taken |=> S_AXI_RVALID;
  endproperty
  a_r_resp: assert property (p_r_resp)
    else $error("read response late");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID;
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped");
  property p_busy;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write taken while response pending");
  property p_rbusy;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_rbusy: assert property (p_rbusy)
    else $error("read taken while response pending");
endmodule : brk_control_asserts
bind brk_control brk_control_asserts brk_control_asserts_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .CYCLE_VALID(CYCLE_VALID),
  .INSN_DONE(INSN_DONE), .PC_TRACE_ON(PC_TRACE_ON),
  .BREAK_REQ(BREAK_REQ), .IRQ(IRQ));

// ==== tb/testbench.sv ====
// self-checking bench for the break condition control block
module testbench
  import brk_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, insn_done;
  logic cyc_valid, cyc_dma, cyc_fetch, addr_a, addr_b, data_b;
  logic pc_trace, dcmp_b, brk_req, irq;
  logic [7:0] awaddr, araddr, cyc_id;
  logic [31:0] wdata, rdata, brk_n, brk_e;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  int err_count, checked;
  localparam logic [31:0] IDM = 32'h0030_0000; // both id masks set
  brk_control brk_control_inst (
    .CLK(clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .CYCLE_VALID(cyc_valid),
    .CYCLE_IS_DMA(cyc_dma), .CYCLE_IS_FETCH(cyc_fetch), .CYCLE_ID(cyc_id),
    .ADDR_MATCH_A(addr_a), .ADDR_MATCH_B(addr_b), .DATA_MATCH_B(data_b),
    .INSN_DONE(insn_done), .PC_TRACE_ON(pc_trace),
    .DATA_COMPARE_ON_B(dcmp_b), .BREAK_REQ(brk_req), .IRQ(irq));
  brk_bus_model bus_model_inst (.clk(clk), .cyc_valid(cyc_valid),
    .cyc_dma(cyc_dma), .cyc_fetch(cyc_fetch), .cyc_id(cyc_id),
    .addr_a(addr_a), .addr_b(addr_b), .data_b(data_b),
    .insn_done(insn_done));
  ////////////////////////////////
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counts break pulses
  always @(posedge clk)
    brk_n <= sys_rst ? 32'h0 : brk_n + 32'(brk_req === 1'b1);
  // hang guard
  initial
  begin
    #2_000_000;
    err_count++;
    give_verdict();
  end
  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  function automatic logic [31:0] bt(input int b);
    return 32'h1 << b;
  endfunction : bt
  // write; response ready rises late to stall the slave
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    logic ta, tw, hs, up;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    repeat (40)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      hs = bvalid & bready;
      up = bvalid & ~bready;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= up;
      if (hs) break;
    end
    chk("bresp", 32'({hs, r}), 32'({1'b1, er}));
    @(negedge clk);
  endtask : wr
  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = RESP_OKAY);
    logic ta, hs, up;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    repeat (40)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      hs = rvalid & rready;
      up = rvalid & ~rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      rready <= up;
      if (hs) break;
    end
    chk("rdata", d, e);
    chk("rresp", 32'({hs, r}), 32'({1'b1, er}));
  endtask : rdc
  // settle, then compare the break count
  task automatic brk(input int e);
    repeat (3) @(negedge clk);
    brk_e += e;
    chk("breaks", brk_n, brk_e);
  endtask : brk
  task automatic cyc(input logic [4:0] k, input logic [7:0] id, int e);
    bus_model_inst.bus_cycle(k, id);
    brk(e);
  endtask : cyc
  ////////////////////////////////
  task automatic t_regs();
    rdc(OFS_CONTROL, 32'h0);
    chk("trace", 32'(pc_trace), 32'h0);
    rdc(OFS_COUNT, 32'h0);
    wr(OFS_ID_A, 32'h5a);
    rdc(OFS_ID_A, 32'h5a);
    wr(OFS_CONTROL, 32'hffff_ffff);
    rdc(OFS_CONTROL, 32'h0030_0cc9);
    chk("trace", 32'(pc_trace), 32'h1);
    chk("dcmp", 32'(dcmp_b), 32'h1);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    wr(OFS_CONTROL, IDM);
  endtask : t_regs
  // each cycle type and channel sets its own sticky flag
  task automatic t_flags();
    for (int i = 0; i < 4; i++)
    begin
      cyc({i[1], 1'b0, ~i[0], i[0], 1'b1}, 8'h00, 1);
      rdc(OFS_CONTROL, IDM | bt(15 - i));
      wr(OFS_CONTROL, IDM | 32'hf000);
      rdc(OFS_CONTROL, IDM | bt(15 - i));
      wr(OFS_CONTROL, IDM);
      rdc(OFS_CONTROL, IDM);
    end
  endtask : t_flags
  // identifier compared while the masks are clear
  task automatic t_ident();
    for (int c = 0; c < 2; c++)
    begin
      wr(OFS_CONTROL, 32'h0);
      wr(c ? OFS_ID_B : OFS_ID_A, 32'h5a);
      cyc({2'b00, ~c[0], c[0], 1'b1}, 8'h33, 0);
      cyc({2'b00, ~c[0], c[0], 1'b1}, 8'h5a, 1);
      rdc(OFS_CONTROL, bt(15 - c));
    end
  endtask : t_ident
  task automatic t_data();
    wr(OFS_CONTROL, IDM | bt(7));
    cyc(5'b00010, 8'h00, 0);
    cyc(5'b00011, 8'h00, 1);
    rdc(OFS_CONTROL, IDM | bt(7) | bt(14));
  endtask : t_data
  // chained channels: b breaks only after a, then rearms
  task automatic t_seq();
    wr(OFS_CONTROL, IDM | bt(3));
    cyc(5'b00101, 8'h00, 0);
    cyc(5'b00011, 8'h00, 1);
    cyc(5'b00011, 8'h00, 0);
  endtask : t_seq
  task automatic t_count();
    wr(OFS_COUNT, 32'h3);
    wr(OFS_CONTROL, IDM | bt(0));
    cyc(5'b00011, 8'h00, 0);
    rdc(OFS_COUNT, 32'h2);
    cyc(5'b00011, 8'h00, 0);
    cyc(5'b00011, 8'h00, 1);
    rdc(OFS_COUNT, 32'h1);
    wr(OFS_COUNT, 32'h0000_0f05, RESP_OKAY, 4'h2);
    rdc(OFS_COUNT, 32'h0000_0f01);
  endtask : t_count
  // fetch break held back until the instruction retires
  task automatic t_after();
    for (int c = 0; c < 2; c++)
    begin
      wr(OFS_CONTROL, IDM | bt(c ? 6 : 10));
      cyc({2'b01, ~c[0], c[0], 1'b1}, 8'h00, 0);
      bus_model_inst.insn();
      brk(1);
    end
  endtask : t_after
  task automatic t_irq();
    wr(OFS_CONTROL, IDM);
    wr(OFS_IRQ_CLEAR, 32'h3);
    wr(OFS_IRQ_ENABLE, 32'h3);
    chk("irq", 32'(irq), 32'h0);
    cyc(5'b00101, 8'h00, 1);
    wr(OFS_IRQ_STATUS, 32'h0);
    rdc(OFS_IRQ_STATUS, 32'h3);
    chk("irq", 32'(irq), 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h3);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h3);
    chk("irq", 32'(irq), 32'h0);
    rdc(OFS_IRQ_CLEAR, 32'h0);
  endtask : t_irq
  ////////////////////////////////
  // main sequence
  initial
  begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_count = 0;
    checked = 0;
    brk_e = 32'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_flags();
    t_ident();
    t_data();
    t_seq();
    t_count();
    t_after();
    t_irq();
    give_verdict();
  end
endmodule : testbench
